// ===== logic/pfw_pkg.sv
// shared constants, register map and field layouts of the pwm block
package pfw_pkg;
    localparam int NGEN = 3;
    localparam int TBW = 16;
    localparam int AW = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PER = 8'h04;
    localparam logic [7:0] OFF_SPER = 8'h08;
    localparam logic [7:0] OFF_SEVT = 8'h0C;
    localparam logic [7:0] OFF_KEY = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_LOCK = 8'h1C;
    localparam logic [3:0] PAGE_GEN0 = 4'h2;
    localparam logic [3:0] PAGE_IOC = 4'h5;
    localparam logic [3:0] PAGE_FCL = 4'h6;

    // control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_SYNCEN = 1;
    localparam int CTRL_SYNCOEN = 2;
    localparam int CTRL_SYNCPOL = 3;
    localparam int CTRL_SEVTSEL = 4;
    localparam int CTRL_PRE = 5;
    localparam int CTRL_W = 8;

    // status / mask fields
    localparam int ST_FLT = 0;
    localparam int ST_SEVT = 3;
    localparam int ST_SYNC = 4;
    localparam int ST_LOCKERR = 5;
    localparam int ST_W = 6;

    localparam logic [15:0] KEY_FIRST = 16'hABCD;
    localparam logic [15:0] KEY_SECOND = 16'h4321;

    localparam logic [TBW-1:0] PER_RST = 16'hFFF8;
    localparam logic [TBW-1:0] SEVT_RST = 16'h0000;

    // timing step of one time-base tick
    localparam int RES_PS = 8320;
    localparam int CLK_PS = 50000;
    localparam int TICK_CYCLES = (RES_PS + CLK_PS - 1) / CLK_PS;

    typedef enum logic [1:0] {
        FM_LATCH = 2'b00,
        FM_CYCLE = 2'b01,
        FM_RSVD = 2'b10,
        FM_OFF = 2'b11
    } pfw_fmode_t;

    localparam logic [1:0] SRC_SAFETY = 2'h0;

    typedef struct packed {
        logic safeLow;
        logic safeHigh;
        logic [1:0] src;
        pfw_fmode_t mode;
    } pfw_fltCtl_t;
    localparam int FCL_W = 6;
    localparam pfw_fltCtl_t FCL_RST = '{1'b0, 1'b0, SRC_SAFETY, FM_LATCH};

    typedef struct packed {
        logic swap;
        logic lowInv;
        logic highInv;
        logic lowEn;
        logic highEn;
    } pfw_ioCtl_t;
    localparam int IOC_W = 5;
    localparam pfw_ioCtl_t IOC_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [TBW-1:0] duty;
        logic [TBW-1:0] phase;
        logic [TBW-1:0] trig;
        logic [7:0] dead;
    } pfw_genCfg_t;
    localparam pfw_genCfg_t GEN_RST = '{16'h0000, 16'h0000, 16'h0000, 8'h00};
endpackage

// ===== logic/pfw_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pfw_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ===== logic/pfw_gen.sv
// one edge-aligned pwm generator with dead time and converter trigger
`timescale 1ns/10ps
module pfw_gen (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic tbStart,
    input wire logic [pfw_pkg::TBW-1:0] period,
    input wire pfw_pkg::pfw_genCfg_t cfg,
    output logic rawHigh,
    output logic rawLow,
    output logic trig
);
    import pfw_pkg::*;

    logic [TBW-1:0] cnt_r;
    logic [7:0] dead_r;
    logic pwmPrev_r;

    wire pwmOn = cnt_r < cfg.duty;
    wire wrap = cnt_r >= period;
    wire pwmEdge = pwmOn != pwmPrev_r;

    // local count restarts at the phase offset on each master period start
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (tbStart) begin
            cnt_r <= cfg.phase;
        end else if (tick) begin
            cnt_r <= wrap ? '0 : cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dead_r <= '0;
            pwmPrev_r <= 1'b0;
        end else begin
            pwmPrev_r <= pwmOn;
            if (pwmEdge) begin
                dead_r <= cfg.dead;
            end else if (tick && dead_r != '0) begin
                dead_r <= dead_r - 1'b1;
            end
        end
    end

    // both sides stay off during the dead interval after every edge
    assign rawHigh = pwmOn & !pwmEdge & (dead_r == '0);
    assign rawLow = !pwmOn & !pwmEdge & (dead_r == '0);
    assign trig = tick & (cnt_r == cfg.trig);
endmodule

// ===== logic/pfw_top.sv
// pwm unit: master time bases, generators, fault safe state, write lock
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module pfw_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic writeProtectCfgBit,
    input wire logic extSyncInput,
    input wire logic safetyFaultInput,
    input wire logic remappableFaultInputOne,
    input wire logic remappableFaultInputTwo,
    output logic [pfw_pkg::NGEN-1:0] highSideOutput,
    output logic [pfw_pkg::NGEN-1:0] lowSideOutput,
    output logic [pfw_pkg::NGEN-1:0] adcTrig,
    output logic specialEventTrig,
    output logic extSyncOutput,
    output logic irq
);
    import pfw_pkg::*;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_OPEN
    } pfw_key_t;

    // ---------------- bus slave ----------------
    logic dpValid_r;
    logic dpWrite_r;
    logic [AW-1:0] dpAddr_r;
    logic rdDone_r;
    logic [31:0] hrdata_r;
    wire addrTake = hsel & htrans[1] & hready;
    // reads take one wait state so read data always comes from a flop
    wire readWait = dpValid_r & !dpWrite_r & !rdDone_r;
    wire accEnd = dpValid_r & !readWait;
    wire wrEn = dpValid_r & dpWrite_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            dpValid_r <= 1'b0;
            dpWrite_r <= 1'b0;
            dpAddr_r <= '0;
        end else if (hready) begin
            dpValid_r <= addrTake;
            dpWrite_r <= hwrite;
            dpAddr_r <= haddr[AW-1:0];
        end
    end
    assign hreadyout = !readWait;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ---------------- decode ----------------
    wire [3:0] page = dpAddr_r[7:4];
    wire [1:0] slot = dpAddr_r[3:2];
    wire [3:0] genPage = page - PAGE_GEN0;
    wire inGen = (page >= PAGE_GEN0) && (genPage < 4'(NGEN));
    wire inIoc = (page == PAGE_IOC) && (slot < 2'(NGEN));
    wire inFcl = (page == PAGE_FCL) && (slot < 2'(NGEN));
    wire isProt = inIoc | inFcl;
    wire selCtrl = dpAddr_r == OFF_CTRL;
    wire selPer = dpAddr_r == OFF_PER;
    wire selSper = dpAddr_r == OFF_SPER;
    wire selSevt = dpAddr_r == OFF_SEVT;
    wire selKey = dpAddr_r == OFF_KEY;
    wire selStat = dpAddr_r == OFF_STAT;
    wire selMask = dpAddr_r == OFF_MASK;
    wire [15:0] wd16 = hwdata[15:0];
    // ---------------- registers ----------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [TBW-1:0] per_r;
    logic [TBW-1:0] sper_r;
    logic [TBW-1:0] sevt_r;
    logic [ST_W-1:0] stat_r;
    logic [ST_W-1:0] stat_nxt;
    logic [ST_W-1:0] mask_r;
    logic lockCfg_r;
    pfw_key_t key_r;
    pfw_key_t key_nxt;
    pfw_genCfg_t genCfg_r [NGEN];
    pfw_ioCtl_t ioc_r [NGEN];
    pfw_fltCtl_t fcl_r [NGEN];

    wire modEn = ctrl_r[CTRL_EN];
    wire syncEn = ctrl_r[CTRL_SYNCEN];
    wire syncOEn = ctrl_r[CTRL_SYNCOEN];
    wire syncPol = ctrl_r[CTRL_SYNCPOL];
    wire sevtSel = ctrl_r[CTRL_SEVTSEL];
    wire [2:0] preSel = ctrl_r[CTRL_PRE +: 3];

    // lock state: a protected write needs the open state or a clear config bit
    wire protOk = !lockCfg_r || key_r == KEY_OPEN;
    wire protWr = wrEn & isProt & protOk;
    wire protErr = wrEn & isProt & !protOk;
    wire keyOne = wrEn & selKey & (wd16 == KEY_FIRST);
    wire keySecond = wrEn & selKey & (wd16 == KEY_SECOND);
    // anything but the expected key, reads included, drops back to idle
    always_comb begin
        key_nxt = key_r;
        if (accEnd) begin
            unique case (key_r)
                KEY_IDLE: key_nxt = keyOne ? KEY_ONE : KEY_IDLE;
                KEY_ONE: key_nxt = keySecond ? KEY_OPEN : KEY_IDLE;
                KEY_OPEN: key_nxt = KEY_IDLE;
                default: key_nxt = KEY_IDLE;
            endcase
        end
    end
    // strap is captured while reset is held, so it is stable afterwards
    always_ff @(posedge clk) begin
        if (reset) begin
            lockCfg_r <= writeProtectCfgBit;
            key_r <= KEY_IDLE;
        end else begin
            key_r <= key_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= '0;
            per_r <= PER_RST;
            sper_r <= PER_RST;
            sevt_r <= SEVT_RST;
            mask_r <= '0;
        end else if (wrEn) begin
            if (selCtrl) ctrl_r <= hwdata[CTRL_W-1:0];
            if (selPer) per_r <= wd16;
            if (selSper) sper_r <= wd16;
            if (selSevt) sevt_r <= wd16;
            if (selMask) mask_r <= hwdata[ST_W-1:0];
        end
    end
    // ---------------- clock divider ----------------
    logic [6:0] div_r;
    wire [6:0] divLast = 7'((TICK_CYCLES << preSel) - 1);
    wire tick = modEn & (div_r >= divLast);

    always_ff @(posedge clk) begin
        if (reset || !modEn || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // ---------------- pin synchronisers ----------------
    logic [3:0] pinQ;
    pfw_sync2 #(
        .W(4),
        .INIT(4'h7)
    ) u_pins (
        .clk(clk),
        .reset(reset),
        .d({extSyncInput, remappableFaultInputTwo, remappableFaultInputOne, safetyFaultInput}),
        .q(pinQ)
    );
    // fault pins are active low
    wire [2:0] fltAct = ~pinQ[2:0];
    wire syncLvl = pinQ[3] ^ syncPol;
    logic syncPrev_r;
    wire syncRise = syncLvl & !syncPrev_r;
    wire syncHit = modEn & syncEn & syncRise;

    // ---------------- master time bases ----------------
    logic [TBW-1:0] tb_r;
    logic [TBW-1:0] stb_r;
    wire tbWrap = tick & (tb_r >= per_r);
    wire stbWrap = tick & (stb_r >= sper_r);
    wire tbStart = tbWrap | syncHit;
    wire [TBW-1:0] sevtBase = sevtSel ? stb_r : tb_r;
    wire sevtHit = tick & (sevtBase == sevt_r);

    always_ff @(posedge clk) begin
        if (reset || !modEn) begin
            tb_r <= '0;
            stb_r <= '0;
        end else begin
            if (tbStart) begin
                tb_r <= '0;
            end else if (tick) begin
                tb_r <= tb_r + 1'b1;
            end
            if (stbWrap) begin
                stb_r <= '0;
            end else if (tick) begin
                stb_r <= stb_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syncPrev_r <= 1'b0;
            specialEventTrig <= 1'b0;
            extSyncOutput <= 1'b0;
        end else begin
            syncPrev_r <= syncLvl;
            specialEventTrig <= sevtHit;
            // idle level follows the chosen polarity
            extSyncOutput <= (syncOEn & tbStart) ^ syncPol;
        end
    end

    // ---------------- generators and faults ----------------
    logic [NGEN-1:0] rawH;
    logic [NGEN-1:0] rawL;
    logic [NGEN-1:0] trigG;
    logic [NGEN-1:0] latch_r;
    logic [NGEN-1:0] cyc_r;
    logic [NGEN-1:0] srcAct;
    logic [NGEN-1:0] fltOn;
    logic [NGEN-1:0] fltEv;
    wire [ST_W-1:0] w1c = (wrEn & selStat) ? hwdata[ST_W-1:0] : '0;

    for (genvar g = 0; g < NGEN; g++) begin : g_gen
        pfw_gen u_gen (
            .clk(clk),
            .reset(reset),
            .tick(tick),
            .tbStart(tbStart),
            .period(per_r),
            .cfg(genCfg_r[g]),
            .rawHigh(rawH[g]),
            .rawLow(rawL[g]),
            .trig(trigG[g])
        );

        wire fltEnG = fcl_r[g].mode != FM_OFF;
        wire isLatch = fcl_r[g].mode == FM_LATCH;
        wire isCyc = fcl_r[g].mode == FM_CYCLE;
        assign srcAct[g] = fcl_r[g].src == 2'd1 ? fltAct[1] :
                           fcl_r[g].src == 2'd2 ? fltAct[2] : fltAct[0];
        assign fltEv[g] = fltEnG & srcAct[g];
        assign fltOn[g] = fltEnG & (latch_r[g] | cyc_r[g] | srcAct[g]);

        wire oH = ioc_r[g].swap ? rawL[g] : rawH[g];
        wire oL = ioc_r[g].swap ? rawH[g] : rawL[g];
        wire runH = ioc_r[g].highEn & modEn & (oH ^ ioc_r[g].highInv);
        wire runL = ioc_r[g].lowEn & modEn & (oL ^ ioc_r[g].lowInv);
        wire genWr = wrEn & inGen & (genPage[1:0] == 2'(g));
        wire iocWr = protWr & inIoc & (slot == 2'(g));
        wire fclWr = protWr & inFcl & (slot == 2'(g));
        wire latchSet = isLatch & srcAct[g];
        // clear refused while the source still pulls low, in any mode
        wire latchClr = w1c[ST_FLT + g] & !srcAct[g];
        wire cycSet = isCyc & srcAct[g];
        always_ff @(posedge clk) begin
            if (reset) begin
                // safety source latched from reset onward
                latch_r[g] <= 1'b1;
                cyc_r[g] <= 1'b0;
            end else begin
                latch_r[g] <= latchSet | (latch_r[g] & !latchClr);
                cyc_r[g] <= cycSet | (cyc_r[g] & !tbStart);
            end
        end
        always_ff @(posedge clk) begin
            if (reset) begin
                genCfg_r[g] <= GEN_RST;
                ioc_r[g] <= IOC_RST;
                fcl_r[g] <= FCL_RST;
            end else begin
                if (genWr) begin
                    unique case (slot)
                        2'd0: genCfg_r[g].duty <= wd16;
                        2'd1: genCfg_r[g].phase <= wd16;
                        2'd2: genCfg_r[g].trig <= wd16;
                        2'd3: genCfg_r[g].dead <= hwdata[7:0];
                    endcase
                end
                if (iocWr) ioc_r[g] <= pfw_ioCtl_t'(hwdata[IOC_W-1:0]);
                if (fclWr) fcl_r[g] <= pfw_fltCtl_t'(hwdata[FCL_W-1:0]);
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                highSideOutput[g] <= FCL_RST.safeHigh;
                lowSideOutput[g] <= FCL_RST.safeLow;
                adcTrig[g] <= 1'b0;
            end else begin
                highSideOutput[g] <= fltOn[g] ? fcl_r[g].safeHigh : runH;
                lowSideOutput[g] <= fltOn[g] ? fcl_r[g].safeLow : runL;
                adcTrig[g] <= trigG[g];
            end
        end
    end

    // ---------------- status and interrupt ----------------
    wire [ST_W-1:0] stSet = {protErr, syncHit, sevtHit, fltEv};
    // a new event in the clearing cycle survives the clear
    assign stat_nxt = (stat_r & ~w1c) | stSet;
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end
    assign irq = |(stat_r & mask_r);

    // ---------------- read mux ----------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        if (selCtrl) rdMux = 32'(ctrl_r);
        if (selPer) rdMux = 32'(per_r);
        if (selSper) rdMux = 32'(sper_r);
        if (selSevt) rdMux = 32'(sevt_r);
        if (selStat) rdMux = 32'(stat_r);
        if (selMask) rdMux = 32'(mask_r);
        if (dpAddr_r == OFF_LOCK) begin
            rdMux = 32'({latch_r, key_r == KEY_ONE, key_r == KEY_OPEN, lockCfg_r});
        end
        for (int i = 0; i < NGEN; i++) begin
            if (inGen && genPage[1:0] == 2'(i)) begin
                unique case (slot)
                    2'd0: rdMux = 32'(genCfg_r[i].duty);
                    2'd1: rdMux = 32'(genCfg_r[i].phase);
                    2'd2: rdMux = 32'(genCfg_r[i].trig);
                    2'd3: rdMux = 32'(genCfg_r[i].dead);
                endcase
            end
            if (inIoc && slot == 2'(i)) rdMux = 32'(ioc_r[i]);
            if (inFcl && slot == 2'(i)) rdMux = 32'(fcl_r[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdDone_r <= 1'b0;
            hrdata_r <= '0;
        end else begin
            rdDone_r <= readWait;
            if (readWait) hrdata_r <= rdMux;
        end
    end
endmodule

// ===== verif/pfw_properties.sv
// concurrent checks on the pwm unit pins and bus handshake
`timescale 1ns/10ps
module pfw_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic safetyFaultInput,
    input wire logic [pfw_pkg::NGEN-1:0] highSideOutput,
    input wire logic [pfw_pkg::NGEN-1:0] lowSideOutput,
    input wire logic [pfw_pkg::NGEN-1:0] adcTrig,
    input wire logic specialEventTrig,
    input wire logic extSyncOutput
);
    import pfw_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // latch is set from reset, so no high or low side pin may move in the 8 cycles after reset falls
    AST_POWERUP_SAFE: assert property (
        $fell(reset) |-> (highSideOutput == 3'h0 && lowSideOutput == 3'h0)[*8])
        else $error("pin driven right after reset");
    // two sync flops plus the output flop
    AST_FAULT_SAFE: assert property (
        $fell(safetyFaultInput) |-> ##3 (highSideOutput == 3'h0 && lowSideOutput == 3'h0))
        else $error("outputs not safe three cycles after fault pin fell");
    AST_PAIR_EXCL: assert property ((highSideOutput & lowSideOutput) == 3'h0)
        else $error("high and low side of one pair on together");
    AST_ADC_PULSE: assert property (|adcTrig |=> (adcTrig & $past(adcTrig)) == 3'h0)
        else $error("converter trigger longer than one cycle");
    AST_SEVT_PULSE: assert property (specialEventTrig |=> !specialEventTrig)
        else $error("special event trigger longer than one cycle");
    AST_SYNC_PULSE: assert property ($rose(extSyncOutput) |=> !extSyncOutput)
        else $error("sync output pulse longer than one cycle");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_READ_WAIT: assert property (
        hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
        else $error("read not answered after exactly one wait cycle");
endmodule

bind pfw_top pfw_properties i_props (
    .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .safetyFaultInput(safetyFaultInput), .highSideOutput(highSideOutput),
    .lowSideOutput(lowSideOutput), .adcTrig(adcTrig),
    .specialEventTrig(specialEventTrig), .extSyncOutput(extSyncOutput)
);

// ===== verif/pfw_stage_model.sv
// far side: power stage on the pins, fault sources and an external sync source
`timescale 1ns/10ps
module pfw_stage_model (
    input wire logic clk,
    input wire logic [pfw_pkg::NGEN-1:0] highSideOutput,
    input wire logic [pfw_pkg::NGEN-1:0] lowSideOutput,
    input wire logic faultCmd,
    input wire logic syncCmd,
    output logic safetyFaultInput,
    output logic faultOne,
    output logic faultTwo,
    output logic extSyncInput,
    output int shootCount
);
    import pfw_pkg::*;
    logic syncCmd_r = 1'b0;
    logic [1:0] pulseLeft = 2'h0;
    // pulled up: sources only ever pull the fault lines low
    assign safetyFaultInput = !faultCmd;
    assign faultOne = !faultCmd;
    assign faultTwo = !faultCmd;
    assign extSyncInput = (pulseLeft != 2'h0);
    initial shootCount = 0;
    always @(posedge clk) begin
        syncCmd_r <= syncCmd;
        if (syncCmd && !syncCmd_r) begin
            pulseLeft <= 2'h2;
        end else if (pulseLeft != 2'h0) begin
            pulseLeft <= pulseLeft - 2'h1;
        end
        // a stage with both switches on shorts the supply
        if ((highSideOutput & lowSideOutput) != 3'h0) begin
            shootCount <= shootCount + 1;
        end
    end
endmodule

// ===== verif/pwm_fault_and_write_lock_tb_top.sv
// self-checking bench: registers, write lock, fault path and pins of the pwm unit
`timescale 1ns/10ps
module pwm_fault_and_write_lock_tb_top;
    import pfw_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } pfw_row_t;
    pfw_row_t rows [8] = '{
        '{OFF_PER, 32'h0000_0008, 32'h0000_0008},
        '{OFF_SEVT, 32'h0000_0003, 32'h0000_0003},
        '{OFF_SPER, 32'h0000_0010, 32'h0000_0010},
        '{8'h20, 32'h0000_0004, 32'h0000_0004},
        '{8'h28, 32'h0000_0002, 32'h0000_0002},
        '{OFF_KEY, 32'h0000_ABCD, 32'h0000_0000},
        '{8'hF0, 32'h0000_1234, 32'h0000_0000},
        '{OFF_MASK, 32'h0000_0020, 32'h0000_0020}
    };
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic cfgBit = 1'b1;
    logic faultCmd = 1'b0;
    logic syncCmd = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic [2:0] highSideOutput, lowSideOutput, adcTrig;
    logic hreadyout, hresp, specialEventTrig, extSyncOutput, irq;
    logic safetyPin, fltOne, fltTwo, extSync;
    int errCount = 0;
    int nCompared = 0;
    int shoot;

    pfw_top i_dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .writeProtectCfgBit(cfgBit), .extSyncInput(extSync),
        .safetyFaultInput(safetyPin), .remappableFaultInputOne(fltOne),
        .remappableFaultInputTwo(fltTwo), .highSideOutput(highSideOutput),
        .lowSideOutput(lowSideOutput), .adcTrig(adcTrig),
        .specialEventTrig(specialEventTrig), .extSyncOutput(extSyncOutput), .irq(irq)
    );
    pfw_stage_model i_stage (
        .clk(clk), .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
        .faultCmd(faultCmd), .syncCmd(syncCmd), .safetyFaultInput(safetyPin),
        .faultOne(fltOne), .faultTwo(fltTwo), .extSyncInput(extSync), .shootCount(shoot)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            errCount++;
            wrapUp();
        end
    endtask
    // address phase held until ready is seen high, then the data phase likewise
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("register %h", a), rd, e);
    endtask
    task automatic unlock;
        wr(OFF_KEY, {16'h0000, KEY_FIRST});
        wr(OFF_KEY, {16'h0000, KEY_SECOND});
    endtask
    task automatic resetDut(logic cfg);
        cfgBit <= cfg;
        reset <= 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic waitEv(string what, int sel);
        logic [3:0] ev;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            ev = {extSyncOutput, specialEventTrig, adcTrig[0], highSideOutput[0]};
            n++;
        end while (ev[sel] !== 1'b1 && n < 300);
        chk(what, 32'(ev[sel]), 32'h0000_0001);
    endtask

    initial begin
        resetDut(1'b1);
        rdc(OFF_LOCK, 32'h0000_0039);
        chk("irq", 32'(irq), 32'h0000_0000);
        // clearing must fail while the pin is still pulled low
        faultCmd <= 1'b1;
        repeat (4) @(posedge clk);
        wr(OFF_STAT, 32'h0000_0007);
        rdc(OFF_LOCK, 32'h0000_0039);
        faultCmd <= 1'b0;
        repeat (4) @(posedge clk);
        wr(OFF_STAT, 32'h0000_0007);
        rdc(OFF_LOCK, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        wr(8'h50, 32'h0000_0003);
        rdc(8'h50, 32'h0000_0000);
        rdc(OFF_STAT, 32'h0000_0020);
        chk("irq", 32'(irq), 32'h0000_0001);
        wr(OFF_MASK, 32'h0000_0000);
        chk("irq", 32'(irq), 32'h0000_0000);
        wr(OFF_MASK, 32'h0000_0020);
        wr(OFF_STAT, 32'h0000_0020);
        chk("irq", 32'(irq), 32'h0000_0000);
        unlock();
        wr(8'h50, 32'h0000_0003);
        rdc(8'h50, 32'h0000_0003);
        wr(8'h50, 32'h0000_0000);
        rdc(8'h50, 32'h0000_0003);
        faultCmd <= 1'b1;
        unlock();
        wr(8'h64, 32'h0000_0003);
        rdc(8'h64, 32'h0000_0003);
        faultCmd <= 1'b0;
        repeat (4) @(posedge clk);
        wr(OFF_STAT, 32'h0000_0027);
        wr(OFF_KEY, {16'h0000, KEY_FIRST});
        wr(OFF_KEY, 32'h0000_1234);
        wr(8'h50, 32'h0000_0000);
        rdc(8'h50, 32'h0000_0003);
        // a read between the keys is an access too and must abort
        wr(OFF_KEY, {16'h0000, KEY_FIRST});
        rdc(OFF_LOCK, 32'h0000_0005);
        wr(OFF_KEY, {16'h0000, KEY_SECOND});
        wr(8'h50, 32'h0000_0000);
        rdc(8'h50, 32'h0000_0003);
        wr(OFF_CTRL, 32'h0000_0005);
        waitEv("high side", 0);
        waitEv("converter trigger", 1);
        waitEv("special event", 2);
        waitEv("sync out", 3);
        wr(OFF_CTRL, 32'h0000_0003);
        syncCmd <= 1'b1;
        repeat (6) @(posedge clk);
        syncCmd <= 1'b0;
        bus(1'b0, OFF_STAT, 32'h0000_0000);
        chk("sync seen", rd & 32'h0000_0010, 32'h0000_0010);
        faultCmd <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("pins", 32'({highSideOutput, lowSideOutput}), 32'h0000_0000);
        faultCmd <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk("pins", 32'({highSideOutput, lowSideOutput}), 32'h0000_0000);
        chk("shoot through", 32'(shoot), 32'h0000_0000);
        resetDut(1'b0);
        bus(1'b0, OFF_LOCK, 32'h0000_0000);
        chk("lock", rd & 32'h0000_0039, 32'h0000_0038);
        wr(8'h54, 32'h0000_0003);
        rdc(8'h54, 32'h0000_0003);
        wrapUp();
    end
endmodule
